// >>> csmc_pkg.sv
// package of register map, field layout and timing constants for the clock control block
package csmc_pkg;
  // register offsets on the special function register bus
  localparam logic [7:0] CSMC_ADDR_CLOCK_SELECT_REG  = 8'h_a9;
  localparam logic [7:0] CSMC_ADDR_EXTOSC  = 8'h_b1;
  localparam logic [7:0] CSMC_ADDR_MULCTL  = 8'h_b9;
  // reset values
  localparam logic [7:0] CSMC_RST_CLOCK_SELECT_REG   = 8'h_00;
  localparam logic [7:0] CSMC_RST_EXTOSC   = 8'h_00;
  localparam logic [7:0] CSMC_RST_MULCTL   = 8'h_00;
  // field positions
  localparam int CSMC_XTL_VALID_BIT        = 7;
  localparam int CSMC_XMODE_LSB            = 4;
  localparam int CSMC_MUL_EN_BIT           = 7;
  localparam int CSMC_MUL_INIT_BIT         = 6;
  localparam int CSMC_MUL_RDY_BIT          = 5;
  localparam int CSMC_USB_SEL_LSB          = 4;
  // source codes
  localparam logic [2:0] CSMC_XMODE_CMOS   = 3'h_2;
  localparam logic [2:0] CSMC_XMODE_CMOS2  = 3'h_3;
  localparam logic [2:0] CSMC_XMODE_RC     = 3'h_4;
  localparam logic [2:0] CSMC_XMODE_CAP    = 3'h_5;
  localparam logic [2:0] CSMC_XMODE_XTAL   = 3'h_6;
  localparam logic [2:0] CSMC_XMODE_XTAL2  = 3'h_7;
  localparam logic [1:0] CSMC_MSEL_INT     = 2'h_0;
  localparam logic [1:0] CSMC_MSEL_EXT     = 2'h_1;
  localparam logic [1:0] CSMC_MSEL_EXT2    = 2'h_2;
  localparam logic [1:0] CSMC_SYS_INT      = 2'h_0;
  localparam logic [1:0] CSMC_SYS_EXT      = 2'h_1;
  localparam logic [1:0] CSMC_SYS_MUL2     = 2'h_2;
  localparam logic [2:0] CSMC_USB_MUL      = 3'h_0;
  localparam logic [2:0] CSMC_USB_INT2     = 3'h_1;
  localparam logic [2:0] CSMC_USB_EXT1     = 3'h_2;
  localparam logic [2:0] CSMC_USB_EXT2     = 3'h_3;
  localparam logic [2:0] CSMC_USB_EXT3     = 3'h_4;
  localparam logic [2:0] CSMC_USB_EXT4     = 3'h_5;
  // timing: 25 MHz clock
  localparam int CSMC_CLK_MHZ              = 25;
  localparam int CSMC_XTL_SETTLE_US        = 1000;
  localparam int CSMC_XTL_SETTLE_CYC       = CSMC_XTL_SETTLE_US * CSMC_CLK_MHZ;
  localparam int CSMC_MUL_LOCK_US          = 5;
  localparam int CSMC_MUL_LOCK_CYC         = CSMC_MUL_LOCK_US * CSMC_CLK_MHZ;
  // multiplier factor
  localparam int CSMC_MUL_FACTOR           = 4;
endpackage

// >>> csmc_div.sv
// integer clock-enable divider: one-cycle pulse every div input ticks
`timescale 1ns/10ps
`default_nettype none
module csmc_div #(
  parameter int W = 3
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // tick input and ratio (0 and 1 both pass ticks through)
  input  wire logic         tick_in,
  input  wire logic [W-1:0] div,
  // divided tick
  output logic              tick_out
);
  logic [W-1:0] cnt;  // ticks seen in current period

  // a zero-width counter cannot exist
  if (W < 1) $error("csmc_div needs a counter width of at least one");

  // count input ticks, emit one pulse per period
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt      <= '0;
      tick_out <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      if (tick_in) begin
        if (cnt + W'(1) >= div) begin
          cnt      <= '0;
          tick_out <= 1'b1;
        end else begin
          cnt <= cnt + W'(1);
        end
      end
    end
  end
endmodule // csmc_div
`default_nettype wire

// >>> csmc_top.sv
// clock source and multiplier control: three registers and tick-rate source routing
// Functional notes
// - crystal valid flag, bit7, read-only
// - decode external oscillator mode field
// - internal oscillator usable immediately when enabled
// - multiplier yields four times its input
// - init ignored unless multiplier already enabled
// - ready flag read-only, set when locked
// - two-bit multiplier input select decode
// - system select 00 internal, 01 external
// - divided multiplier output selectable as system
// - external tick stays available for peripherals
// - usb codes 000 through 101 routed
`timescale 1ns/10ps
`default_nettype none
module csmc_top
  import csmc_pkg::*;
#(
  parameter int XTL_SETTLE = CSMC_XTL_SETTLE_CYC,  // crystal amplitude settle count
  parameter int MUL_LOCK   = CSMC_MUL_LOCK_CYC     // multiplier lock count
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // special function register port
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_we,
  input  wire logic       sfr_re,
  output logic      [7:0] sfr_rdata,
  // raw source activity (one tick per source edge, asynchronous levels)
  input  wire logic       int_osc_tick,
  input  wire logic       ext_osc_tick,
  input  wire logic       int_osc_div_tick,
  // derived tick outputs
  output logic            sysclk_tick,
  output logic            usb_clock_source_field_tick,
  output logic            periph_ext_tick,
  output logic            mult_tick,
  output logic            ext_osc_enable,
  output logic            mult_enable
);
  // counts below one would wrap the settle and lock compares
  if (XTL_SETTLE < 1 || MUL_LOCK < 1) $error("settle and lock counts must be at least one");
  // register state
  logic [2:0] ext_osc_mode_field;      // external oscillator mode
  logic [2:0] ext_osc_freq_range;      // frequency range, drives analog only
  logic       crystal_valid_flag;      // settled indication
  logic       mult_enable_bit, mult_init_bit, mult_ready_flag;  // multiplier control and status
  logic [1:0] mult_input_select, sysclk_source_field;         // source selects
  logic [2:0] usb_clock_source_field;
  // source synchronisers, first stage read only by second
  logic [2:0] sync1, sync2, sync3;
  logic       int_t, ext_t, intd_t;
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1 <= 3'h_0;
      sync2 <= 3'h_0;
      sync3 <= 3'h_0;
    end else begin
      sync1 <= {int_osc_tick, ext_osc_tick, int_osc_div_tick};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end
  // rising edges of synchronised sources
  assign {int_t, ext_t, intd_t} = sync2 & ~sync3;

  // external oscillator enabled for any mode other than off
  logic ext_on, xtal_mode, ext_half;  // mode decodes
  assign ext_on = ext_osc_mode_field[2] | ext_osc_mode_field[1];
  assign xtal_mode = (ext_osc_mode_field == CSMC_XMODE_XTAL) ||
                     (ext_osc_mode_field == CSMC_XMODE_XTAL2);
  // modes with a divide-by-two stage
  assign ext_half = (ext_osc_mode_field == CSMC_XMODE_CMOS2) ||
                    (ext_osc_mode_field == CSMC_XMODE_XTAL2);

  // external oscillator control register write
  always_ff @(posedge clk) begin
    if (rst) begin
      ext_osc_mode_field <= CSMC_RST_EXTOSC[6:4];
      ext_osc_freq_range <= CSMC_RST_EXTOSC[2:0];
    end else if (sfr_we && sfr_addr == CSMC_ADDR_EXTOSC) begin
      ext_osc_mode_field <= sfr_wdata[CSMC_XMODE_LSB +: 3];
      ext_osc_freq_range <= sfr_wdata[2:0];
    end
  end

  // crystal settle counter; rc, cap and cmos modes need no wait
  logic [$clog2(XTL_SETTLE+1)-1:0] xtl_cnt;
  always_ff @(posedge clk) begin
    if (rst) begin
      xtl_cnt            <= '0;
      crystal_valid_flag <= 1'b0;
    end else if (!ext_on) begin
      xtl_cnt            <= '0;
      crystal_valid_flag <= 1'b0;
    end else if (!xtal_mode || xtl_cnt >= XTL_SETTLE[$bits(xtl_cnt)-1:0] - 1'b1) begin
      xtl_cnt            <= xtal_mode ? xtl_cnt : '0;  // re-arm the wait outside crystal
      crystal_valid_flag <= 1'b1;
    end else begin
      xtl_cnt            <= xtl_cnt + 1'b1;
      crystal_valid_flag <= 1'b0;  // switching into crystal drops a stale flag
    end
  end

  // multiplier control register; init only accepted while already enabled
  always_ff @(posedge clk) begin
    if (rst) begin
      mult_enable_bit   <= CSMC_RST_MULCTL[CSMC_MUL_EN_BIT];
      mult_init_bit     <= CSMC_RST_MULCTL[CSMC_MUL_INIT_BIT];
      mult_input_select <= CSMC_RST_MULCTL[1:0];
    end else if (sfr_we && sfr_addr == CSMC_ADDR_MULCTL) begin
      mult_enable_bit   <= sfr_wdata[CSMC_MUL_EN_BIT];
      mult_init_bit     <= sfr_wdata[CSMC_MUL_INIT_BIT] & mult_enable_bit &
                           sfr_wdata[CSMC_MUL_EN_BIT];
      mult_input_select <= sfr_wdata[1:0];
    end
  end

  // lock timer runs from init; losing enable or init drops ready
  logic [$clog2(MUL_LOCK+1)-1:0] lock_cnt;
  always_ff @(posedge clk) begin
    if (rst) begin
      lock_cnt        <= '0;
      mult_ready_flag <= 1'b0;
    end else if (!(mult_enable_bit && mult_init_bit)) begin
      lock_cnt        <= '0;
      mult_ready_flag <= 1'b0;
    end else if (lock_cnt >= MUL_LOCK[$bits(lock_cnt)-1:0] - 1'b1) begin
      mult_ready_flag <= 1'b1;
    end else begin
      lock_cnt <= lock_cnt + 1'b1;
    end
  end

  // clock select register
  always_ff @(posedge clk) begin
    if (rst) begin
      sysclk_source_field    <= CSMC_RST_CLOCK_SELECT_REG[1:0];
      usb_clock_source_field <= CSMC_RST_CLOCK_SELECT_REG[6:4];
    end else if (sfr_we && sfr_addr == CSMC_ADDR_CLOCK_SELECT_REG) begin
      sysclk_source_field    <= sfr_wdata[1:0];
      usb_clock_source_field <= sfr_wdata[CSMC_USB_SEL_LSB +: 3];
    end
  end

  // external tick after the optional mode divide-by-two
  logic ext_ph, ext_eff;
  always_ff @(posedge clk) begin
    if (rst) begin
      ext_ph <= 1'b0;
    end else if (ext_t) begin
      ext_ph <= ~ext_ph;
    end
  end
  assign ext_eff = ext_on & ext_t & (~ext_half | ext_ph);
  // external dividers by 2, 3 and 4 share one pattern; by 2 also feeds the multiplier
  logic [4:2] ext_dn;  // external tick divided by index
  logic       mul_in;  // selected multiplier input tick
  for (genvar k = 2; k <= 4; k++) begin : g_ext_div
    csmc_div #(.W(3)) u_div (
      .clk(clk), .rst(rst), .tick_in(ext_eff), .div(3'(k)), .tick_out(ext_dn[k])
    );
  end
  // multiplier input mux, halved external on code 10
  always_comb begin
    case (mult_input_select)
      CSMC_MSEL_INT:  mul_in = int_t;
      CSMC_MSEL_EXT:  mul_in = ext_eff;
      CSMC_MSEL_EXT2: mul_in = ext_dn[2];
      default:        mul_in = 1'b0;
    endcase
  end

  // multiplier model: each input tick becomes four output ticks
  logic [1:0] mul_burst;
  logic       mul_out;
  always_ff @(posedge clk) begin
    if (rst) begin
      mul_burst <= 2'h_0;
    end else if (mult_ready_flag && mul_in) begin
      mul_burst <= 2'(CSMC_MUL_FACTOR - 1);
    end else if (mul_burst != 2'h_0) begin
      mul_burst <= mul_burst - 2'h_1;
    end
  end
  assign mul_out = mult_ready_flag & (mul_in | (mul_burst != 2'h_0));
  // derived dividers for system and usb paths
  logic mul_h2, int_h2;
  csmc_div #(.W(2)) u_mul2 (
    .clk(clk), .rst(rst), .tick_in(mul_out), .div(2'h_2), .tick_out(mul_h2)
  );
  csmc_div #(.W(2)) u_int2 (
    .clk(clk), .rst(rst), .tick_in(int_t), .div(2'h_2), .tick_out(int_h2)
  );
  // output routing, all registered; internal path needs no settle gate
  always_ff @(posedge clk) begin
    if (rst) begin
      sysclk_tick     <= 1'b0;
      usb_clock_source_field_tick     <= 1'b0;
      periph_ext_tick <= 1'b0;
      mult_tick       <= 1'b0;
      ext_osc_enable  <= 1'b0;
      mult_enable     <= 1'b0;
    end else begin
      case (sysclk_source_field)
        CSMC_SYS_INT:  sysclk_tick <= intd_t;
        CSMC_SYS_EXT:  sysclk_tick <= ext_eff;
        CSMC_SYS_MUL2: sysclk_tick <= mul_h2;
        default:       sysclk_tick <= 1'b0;
      endcase
      case (usb_clock_source_field)
        CSMC_USB_MUL:  usb_clock_source_field_tick <= mul_out;
        CSMC_USB_INT2: usb_clock_source_field_tick <= int_h2;
        CSMC_USB_EXT1: usb_clock_source_field_tick <= ext_eff;
        CSMC_USB_EXT2: usb_clock_source_field_tick <= ext_dn[2];
        CSMC_USB_EXT3: usb_clock_source_field_tick <= ext_dn[3];
        CSMC_USB_EXT4: usb_clock_source_field_tick <= ext_dn[4];
        default:       usb_clock_source_field_tick <= 1'b0;
      endcase
      periph_ext_tick <= ext_eff;  // independent of system select
      mult_tick       <= mul_out;
      ext_osc_enable  <= ext_on;
      mult_enable     <= mult_enable_bit;
    end
  end

  // read path; reserved bits read zero, unmapped reads zero
  always_ff @(posedge clk) begin
    if (rst) begin
      sfr_rdata <= 8'h_00;
    end else if (sfr_re) begin
      if (sfr_addr == CSMC_ADDR_EXTOSC) begin
        sfr_rdata <= {crystal_valid_flag, ext_osc_mode_field, 1'b0,
                      ext_osc_freq_range};
      end else if (sfr_addr == CSMC_ADDR_MULCTL) begin
        sfr_rdata <= {mult_enable_bit, mult_init_bit, mult_ready_flag, 3'h_0,
                      mult_input_select};
      end else if (sfr_addr == CSMC_ADDR_CLOCK_SELECT_REG) begin
        sfr_rdata <= {1'b0, usb_clock_source_field, 2'h_0, sysclk_source_field};
      end else begin
        sfr_rdata <= 8'h_00;
      end
    end
  end
  // assertions
  property p_xtl_off;
    @(posedge clk) disable iff (rst) !ext_on |=> !crystal_valid_flag;
  endproperty
  a_xtl_off: assert property (p_xtl_off) else $error("valid set while off");
  property p_ready_drop;
    @(posedge clk) disable iff (rst) !mult_enable_bit |=> !mult_ready_flag;
  endproperty
  a_ready_drop: assert property (p_ready_drop) else $error("ready without enable");
  property p_init_needs_en;
    @(posedge clk) disable iff (rst)
      (sfr_we && sfr_addr == CSMC_ADDR_MULCTL && !mult_enable_bit) |=> !mult_init_bit;
  endproperty
  a_init_needs_en: assert property (p_init_needs_en) else $error("init before enable");
  property p_sys_ext;
    @(posedge clk) disable iff (rst)
      (sysclk_source_field == CSMC_SYS_EXT && $stable(sysclk_source_field)) |=>
      (sysclk_tick == $past(ext_eff));
  endproperty
  a_sys_ext: assert property (p_sys_ext) else $error("system external route");
  property p_periph;
    @(posedge clk) disable iff (rst) ext_eff |=> periph_ext_tick;
  endproperty
  a_periph: assert property (p_periph) else $error("peripheral tick lost");
  property p_mul_x4;
    @(posedge clk) disable iff (rst)
      (mult_ready_flag && mul_in && mul_burst == 2'h_0) ##1 mult_ready_flag[*3] |->
      mul_out && $past(mul_out, 3) && $past(mul_out, 2) && $past(mul_out, 1);
  endproperty
  a_mul_x4: assert property (p_mul_x4) else $error("multiplier burst short");
  property p_usb_mul;
    @(posedge clk) disable iff (rst)
      (usb_clock_source_field == CSMC_USB_MUL && mul_out) |=> usb_clock_source_field_tick;
  endproperty
  a_usb_mul: assert property (p_usb_mul) else $error("usb multiplier route");
  property p_sys_res;
    @(posedge clk) disable iff (rst) (sysclk_source_field == 2'h_3) |=> !sysclk_tick;
  endproperty
  a_sys_res: assert property (p_sys_res) else $error("reserved system code ticks");
endmodule // csmc_top
`default_nettype wire

// >>> csmc_top_tb_top.sv
// self-checking bench for the clock source and multiplier control block
`timescale 1ns/10ps
`default_nettype none
module csmc_top_tb_top;
  import csmc_pkg::*;
  // compare one value, count it, report a miss
  `define CHK(nm, e, a) begin compares++; if ((a) !== (e)) begin error_cnt++; \
    $display("MISMATCH %s exp %0h got %0h", nm, e, a); end end
  // clock, reset and register port
  logic       clk;
  logic       rst;
  logic [7:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic       sfr_we;
  logic       sfr_re;
  logic [7:0] sfr_rdata;
  // source levels and derived ticks
  logic       int_osc_tick, ext_osc_tick, int_osc_div_tick;
  logic       sysclk_tick, usb_clock_source_field_tick, periph_ext_tick, mult_tick;
  logic       ext_osc_enable, mult_enable;
  // bench state
  int         error_cnt, compares, cs, cu, cp, cm, m, c;
  logic [7:0] cyc;
  int         ue[8] = '{128, 16, 16, 8, 5, 4, 0, 0};  // usb ticks per window
  int         ut[8] = '{4, 1, 1, 1, 2, 1, 0, 0};      // slack for window edges
  localparam int XTL_SIM  = 20;  // shortened crystal settle count
  localparam int LOCK_SIM = 8;   // shortened multiplier lock count

  // short settle and lock counts keep the run brief
  csmc_top #(.XTL_SETTLE(XTL_SIM), .MUL_LOCK(LOCK_SIM)) DUT (
    .clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_we(sfr_we), .sfr_re(sfr_re), .sfr_rdata(sfr_rdata),
    .int_osc_tick(int_osc_tick), .ext_osc_tick(ext_osc_tick),
    .int_osc_div_tick(int_osc_div_tick), .sysclk_tick(sysclk_tick),
    .usb_clock_source_field_tick(usb_clock_source_field_tick), .periph_ext_tick(periph_ext_tick),
    .mult_tick(mult_tick), .ext_osc_enable(ext_osc_enable), .mult_enable(mult_enable));

  // 25 MHz clock
  always #20 clk = ~clk;

  // source levels: internal edge every 8, external every 16, divided every 32
  // cycles; 8 keeps the x4 bursts from overlapping
  always @(posedge clk) begin
    cyc              <= cyc + 8'h_01;
    int_osc_tick     <= cyc[2];
    ext_osc_tick     <= cyc[3];
    int_osc_div_tick <= cyc[4];
  end

  // verdict and end of run
  task automatic results();
    if (error_cnt == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // register write, then two idle cycles so flags settle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_we    <= 1'b1;
    sfr_addr  <= a;
    sfr_wdata <= d;
    @(posedge clk);
    sfr_we <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  // register read; data is looked at once the read edge has landed
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge clk);
    sfr_re   <= 1'b1;
    sfr_addr <= a;
    @(posedge clk);
    sfr_re <= 1'b0;
    @(negedge clk);
    q = sfr_rdata;
  endtask

  // read and compare
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    rd(a, q);
    `CHK("sfr_rdata", e, q)
  endtask

  // poll one status bit, bounded; running out ends the run
  task automatic poll(input logic [7:0] a, input int b);
    logic [7:0] q;
    int         i;
    for (i = 0; i < 40; i++) begin
      rd(a, q);
      if (q[b] === 1'b1) break;
    end
    if (i == 40) begin
      error_cnt++;
      $display("MISMATCH status bit exp 1 got 0");
      results();
    end
  endtask

  // count each tick output over 256 cycles after a short lag
  task automatic meas();
    cs = 0;
    cu = 0;
    cp = 0;
    cm = 0;
    repeat (16) @(posedge clk);
    repeat (256) begin
      @(negedge clk);
      cs += int'(sysclk_tick);
      cu += int'(usb_clock_source_field_tick);
      cp += int'(periph_ext_tick);
      cm += int'(mult_tick);
    end
  endtask

  // count within a tolerance
  task automatic rng(input string nm, input int n, input int e, input int t);
    compares++;
    if (n < e - t || n > e + t) begin
      error_cnt++;
      $display("MISMATCH %s exp %0d got %0d", nm, e, n);
    end
  endtask

  // multiplier bring-up in the documented order, ready bit written 1 is ignored
  task automatic mul_up(input logic [1:0] s);
    wr(CSMC_ADDR_MULCTL, 8'h_00);
    wr(CSMC_ADDR_MULCTL, {6'h_00, s});
    wr(CSMC_ADDR_MULCTL, {3'b101, 3'b000, s});
    rchk(CSMC_ADDR_MULCTL, {3'b100, 3'b000, s});
    repeat (CSMC_MUL_LOCK_CYC + 1) @(posedge clk); // more than 5 us after enable
    wr(CSMC_ADDR_MULCTL, {3'b110, 3'b000, s});
    rchk(CSMC_ADDR_MULCTL, {3'b110, 3'b000, s});
    poll(CSMC_ADDR_MULCTL, CSMC_MUL_RDY_BIT);
    rchk(CSMC_ADDR_MULCTL, {3'b111, 3'b000, s});
  endtask

  // main sequence
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    cyc = 8'h_00;
    {sfr_addr, sfr_wdata, sfr_we, sfr_re} = '0;
    {int_osc_tick, ext_osc_tick, int_osc_div_tick} = '0;
    error_cnt = 0;
    compares = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // reset values and an unmapped address
    rchk(CSMC_ADDR_CLOCK_SELECT_REG, 8'h_00);
    rchk(CSMC_ADDR_EXTOSC, 8'h_00);
    rchk(CSMC_ADDR_MULCTL, 8'h_00);
    rchk(8'h_b2, 8'h_00);
    meas();
    rng("sysclk_tick", cs, 8, 1);
    // every external mode; system moves to external only once it is settled
    for (m = 0; m < 8; m++) begin
      wr(CSMC_ADDR_CLOCK_SELECT_REG, 8'h_00); // park on internal while the source changes
      wr(CSMC_ADDR_EXTOSC, 8'h_00);
      wr(CSMC_ADDR_EXTOSC, {1'b1, m[2:0], 4'h_7});
      if (m >= 6) begin
        rchk(CSMC_ADDR_EXTOSC, {1'b0, m[2:0], 4'h_7});
        repeat (XTL_SIM) @(posedge clk);
        poll(CSMC_ADDR_EXTOSC, CSMC_XTL_VALID_BIT);
      end
      rchk(CSMC_ADDR_EXTOSC, {m >= 2, m[2:0], 4'h_7});
      `CHK("ext_osc_enable", m >= 2, ext_osc_enable)
      if (m >= 2) wr(CSMC_ADDR_CLOCK_SELECT_REG, 8'h_01);
      meas();
      rng("sysclk_tick", cs, (m < 2 || m == 3 || m == 7) ? 8 : 16, 1);
      rng("periph_ext_tick", cp, m < 2 ? 0 : (m == 3 || m == 7) ? 8 : 16, m >= 2);
    end
    // external stays on for peripherals while internal drives the system
    wr(CSMC_ADDR_CLOCK_SELECT_REG, 8'h_00);
    wr(CSMC_ADDR_EXTOSC, 8'h_27);
    meas();
    rng("periph_ext_tick", cp, 16, 1);
    rng("sysclk_tick", cs, 8, 1);
    // init written while disabled is dropped
    wr(CSMC_ADDR_MULCTL, 8'h_40);
    rchk(CSMC_ADDR_MULCTL, 8'h_00);
    mul_up(CSMC_MSEL_INT);
    `CHK("mult_enable", 1'b1, mult_enable)
    meas();
    rng("mult_tick", cm, 128, 4);
    wr(CSMC_ADDR_CLOCK_SELECT_REG, 8'h_02);
    meas();
    rng("sysclk_tick", cs, 64, 3);
    wr(CSMC_ADDR_CLOCK_SELECT_REG, 8'h_03);
    meas();
    rng("sysclk_tick", cs, 0, 0);
    // every usb code; unused bits read zero
    for (c = 0; c < 8; c++) begin
      wr(CSMC_ADDR_CLOCK_SELECT_REG, {1'b0, c[2:0], 4'h_0});
      rchk(CSMC_ADDR_CLOCK_SELECT_REG, {1'b0, c[2:0], 4'h_0});
      meas();
      rng("usb_clock_source_field_tick", cu, ue[c], ut[c]);
    end
    wr(CSMC_ADDR_CLOCK_SELECT_REG, 8'h_ff);
    rchk(CSMC_ADDR_CLOCK_SELECT_REG, 8'h_73);
    // external inputs to the multiplier, oscillator already running
    mul_up(CSMC_MSEL_EXT);
    meas();
    rng("mult_tick", cm, 64, 4);
    mul_up(CSMC_MSEL_EXT2);
    meas();
    rng("mult_tick", cm, 32, 4);
    // disabling drops ready and output
    wr(CSMC_ADDR_MULCTL, 8'h_00);
    rchk(CSMC_ADDR_MULCTL, 8'h_00);
    `CHK("mult_enable", 1'b0, mult_enable)
    meas();
    rng("mult_tick", cm, 0, 0);
    // low-speed usb from a crystal: external divided by four
    wr(CSMC_ADDR_EXTOSC, 8'h_00);
    wr(CSMC_ADDR_EXTOSC, 8'h_67);
    repeat (XTL_SIM) @(posedge clk);
    poll(CSMC_ADDR_EXTOSC, CSMC_XTL_VALID_BIT);
    wr(CSMC_ADDR_CLOCK_SELECT_REG, {1'b0, CSMC_USB_EXT4, 4'h_0});
    meas();
    rng("usb_clock_source_field_tick", cu, 4, 1);
    results();
  end
endmodule // csmc_top_tb_top
`default_nettype wire
